// >>> rtl/startup_ctrl_defs.vh
`ifndef STARTUP_CTRL_DEFS_VH
`define STARTUP_CTRL_DEFS_VH
// Register indices (byte address is index times four)
`define REG_PTR_IDX       6'h0D
`define REG_WORD_IDX      6'h0E
`define REG_STARTUP_IDX   6'h0F
`define REG_STATUS_IDX    6'h10
`define REG_CMD_IDX       6'h11
`define ADDR_W            8
// Reset values
`define STARTUP_RST       16'h0037
`define WORD_RST          16'h0000
`define PTR_RST           6'h00
// Startup control fields
`define F_KEY_HI          15
`define F_KEY_LO          12
`define F_RSVD_HI         11
`define F_RSVD_LO         9
`define F_FB_AUTO         8
`define F_SKIP_CAL        7
`define F_SKIP_CFG        6
`define F_MUTE_CAL        5
`define F_REFDIV_HI       4
`define F_REFDIV_LO       3
`define F_SCL_FILT        2
`define F_SDA_FILT        1
`define F_AUTO_CAL        0
`define KEY_OPEN          4'h5
// Command register bits
`define CMD_COMMIT        0
`define CMD_CAL           1
// Sequencer states
`define ST_IDLE           3'h0
`define ST_LOAD           3'h1
`define ST_COARSE         3'h2
`define ST_FINE           3'h3
`define ST_DONE           3'h4
// Feedback divider values chosen by the sequencer
`define FB_NDIV_AUTO      15'h0064
`define FB_PRESC_AUTO     2'h1
// Glitch filter depth in clock cycles
`define FILT_CYCLES       3
`endif

// >>> rtl/pin_glitch_filter.v
`default_nettype none
// Passes a pin only after it stays stable for DEPTH cycles, or raw when off
module pin_glitch_filter #(
  parameter DEPTH = 3
) (
  input  wire ref_clk_i,
  input  wire rstn_i,
  input  wire ce_i,
  input  wire en_i,
  input  wire pin_i,
  output wire pin_o
);
  reg  [DEPTH-1:0] hist_r;
  reg              stable_r;
  wire             all_one;
  wire             all_zero;

  assign all_one  = &hist_r;
  assign all_zero = ~|hist_r;

  // History shift and settled level
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      hist_r   <= {DEPTH{1'b1}};
      stable_r <= 1'b1;
    end
    else if (ce_i)
    begin
      hist_r <= {hist_r[DEPTH-2:0], pin_i};
      if (all_one)
        stable_r <= 1'b1;
      else if (all_zero)
        stable_r <= 1'b0;
    end
  end

  assign pin_o = en_i ? stable_r : pin_i;
endmodule // pin_glitch_filter
`default_nettype wire

// >>> rtl/startup_cal_and_nvm_program_ctrl.v
// Our own choice: the address-and-strobe port.
`default_nettype none
`include "startup_ctrl_defs.vh"
// Behaviour
// (RULE1) Data word write programs NVM at pointer
// (RULE2) Pointer advances after each data write
// (RULE3) Only key 5h unlocks; others lock
// (RULE4) Locked key refuses programming and commit
// (RULE5) Auto bit lets sequencer set feedback divider
// (RULE6) Coarse calibration round precedes fine round
// (RULE7) Skip bit bypasses both calibration rounds
// (RULE8) Skip-config clears at power-on; soft reset honours
// (RULE9) Mute outputs during calibration when enabled
// (RULE10) Calibration reference divided by two to power
// (RULE11) Glitch filter on serial clock pin three
// (RULE12) Glitch filter on serial data pin two
// (RULE13) Auto calibration at power-up and reload
// (RULE14) Pointer write starts programming sequence
// (RULE15) Reserved bits store and read back only
module startup_cal_and_nvm_program_ctrl #(
  parameter ROUND_CYCLES = 16,
  parameter LOAD_CYCLES  = 8
) (
  input  wire        ref_clk_i,
  input  wire        rstn_i,
  input  wire        soft_rst_i,
  input  wire        ce_i,
  input  wire [7:0]  addr_i,
  input  wire [15:0] wdata_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [15:0] rdata_o,
  input  wire        multi_pin_three_i,
  input  wire        multi_pin_two_i,
  output wire        serial_clock_o,
  output wire        serial_data_o,
  output reg         nvm_prog_o,
  output reg  [5:0]  nvm_prog_addr_o,
  output reg  [15:0] nvm_prog_data_o,
  output reg         nvm_commit_o,
  output reg         cfg_load_o,
  input  wire        nvm_busy_i,
  output reg         coarse_calibration_o,
  output reg         fine_calibration_o,
  output reg         outputs_mute_o,
  output reg  [3:0]  phase_detector_div_o,
  output reg         fb_auto_o,
  output reg  [14:0] fb_ndiv_o,
  output reg  [1:0]  fb_presc_o,
  output reg         cal_done_o
);
  // Register copies
  reg  [15:0] startup_r;
  reg  [15:0] word_r;
  reg  [5:0]  ptr_r;
  reg         seq_active_r;
  reg  [1:0]  refused_r;
  reg  [15:0] rdata_nxt;

  // Startup sequencer
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [15:0] cnt_r;
  reg  [15:0] cnt_nxt;
  wire        cal_req;
  wire        cal_run;

  // Bus decode and programming requests
  wire [5:0]  idx;
  wire        hit_word;
  wire        hit_ptr;
  wire        hit_start;
  wire        hit_cmd;
  wire        hit_status;
  wire        unlocked;
  wire        prog_req;
  wire        prog_ok;
  wire        prog_refused;
  wire        commit_req;
  wire        commit_ok;
  wire        commit_refused;
  wire [15:0] status_word;

  assign idx       = addr_i[7:2];
  assign hit_word  = (idx == `REG_WORD_IDX);
  assign hit_ptr   = (idx == `REG_PTR_IDX);
  assign hit_start = (idx == `REG_STARTUP_IDX);
  assign hit_cmd   = (idx == `REG_CMD_IDX);
  assign hit_status = (idx == `REG_STATUS_IDX);
  // Unlocked only by the exact key value
  assign unlocked  = (startup_r[`F_KEY_HI:`F_KEY_LO] == `KEY_OPEN); // RULE3
  assign cal_req   = wr_i && hit_cmd && wdata_i[`CMD_CAL];
  assign cal_run   = (state_r == `ST_COARSE) || (state_r == `ST_FINE);

  // Programming and commit are taken only when unlocked and idle
  assign prog_req       = wr_i && hit_word;
  assign prog_ok        = prog_req && unlocked && seq_active_r &&
                          !nvm_busy_i; // RULE4
  assign prog_refused   = prog_req && !prog_ok;
  assign commit_req     = wr_i && hit_cmd && wdata_i[`CMD_COMMIT];
  assign commit_ok      = commit_req && unlocked && !nvm_busy_i; // RULE4
  assign commit_refused = commit_req && !commit_ok;

  // Status word: refusals, pointer written, key state, sequencer
  assign status_word = {8'h00, refused_r, seq_active_r, unlocked,
                        state_r, cal_done_o};

  // Startup control; skip-config only zero after async power-on reset
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      startup_r <= `STARTUP_RST; // RULE8
    else if (ce_i && wr_i && hit_start)
      startup_r <= wdata_i; // RULE15
  end

  // Program pointer and data word, programming and commit pulses
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      word_r          <= `WORD_RST;
      ptr_r           <= `PTR_RST;
      seq_active_r    <= 1'b0;
      nvm_prog_o      <= 1'b0;
      nvm_prog_addr_o <= 6'h00;
      nvm_prog_data_o <= 16'h0000;
      nvm_commit_o    <= 1'b0;
    end
    else if (ce_i)
    begin
      nvm_prog_o   <= prog_ok; // RULE1
      nvm_commit_o <= commit_ok; // RULE4
      if (wr_i && hit_ptr)
      begin
        ptr_r        <= wdata_i[5:0]; // RULE14
        seq_active_r <= 1'b1; // RULE14
      end
      else if (prog_req)
        word_r <= wdata_i;
      if (prog_ok)
      begin
        nvm_prog_addr_o <= ptr_r; // RULE1
        nvm_prog_data_o <= wdata_i; // RULE1
        ptr_r           <= ptr_r + 6'h01; // RULE2
      end
    end
  end

  // Refusal flags; a refusal in the cycle of a status read wins
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      refused_r <= 2'h0;
    else if (ce_i)
    begin
      if (rd_i && hit_status)
        refused_r <= 2'h0;
      if (prog_refused)
        refused_r[0] <= 1'b1; // RULE4
      if (commit_refused)
        refused_r[1] <= 1'b1; // RULE4
    end
  end

  // Startup sequencer next-state logic
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      `ST_IDLE:
      begin
        if (cal_req && !startup_r[`F_SKIP_CAL])
        begin
          state_nxt = `ST_COARSE;
          cnt_nxt   = 16'h0000;
        end
      end
      `ST_LOAD:
      begin
        if (cnt_r == LOAD_CYCLES - 1)
        begin
          cnt_nxt = 16'h0000;
          // Calibrate after load only when enabled and not skipped
          if (startup_r[`F_AUTO_CAL] && !startup_r[`F_SKIP_CAL]) // RULE13
            state_nxt = `ST_COARSE; // RULE7
          else
            state_nxt = `ST_DONE;
        end
        else
          cnt_nxt = cnt_r + 16'h0001;
      end
      `ST_COARSE:
      begin
        if (cnt_r == ROUND_CYCLES - 1)
        begin
          state_nxt = `ST_FINE; // RULE6
          cnt_nxt   = 16'h0000;
        end
        else
          cnt_nxt = cnt_r + 16'h0001;
      end
      `ST_FINE:
      begin
        if (cnt_r == ROUND_CYCLES - 1)
        begin
          state_nxt = `ST_DONE; // RULE6
          cnt_nxt   = 16'h0000;
        end
        else
          cnt_nxt = cnt_r + 16'h0001;
      end
      `ST_DONE:
      begin
        if (cal_req && !startup_r[`F_SKIP_CAL]) // RULE7
        begin
          state_nxt = `ST_COARSE;
          cnt_nxt   = 16'h0000;
        end
      end
      default:
      begin
        state_nxt = `ST_IDLE;
        cnt_nxt   = 16'h0000;
      end
    endcase
  end

  // Sequencer state; soft reset reruns load unless config is skipped; calibration follows when enabled
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state_r <= `ST_LOAD; // RULE13
      cnt_r   <= 16'h0000;
    end
    else if (ce_i)
    begin
      if (soft_rst_i)
      begin
        cnt_r <= 16'h0000;
        if (!startup_r[`F_SKIP_CFG])
          state_r <= `ST_LOAD; // RULE8
        else if (startup_r[`F_AUTO_CAL] && !startup_r[`F_SKIP_CAL])
          state_r <= `ST_COARSE;
        else
          state_r <= `ST_DONE;
      end
      else
      begin
        state_r <= state_nxt;
        cnt_r   <= cnt_nxt;
      end
    end
  end

  // Calibration side outputs from flip-flops
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cfg_load_o           <= 1'b0;
      coarse_calibration_o <= 1'b0;
      fine_calibration_o   <= 1'b0;
      outputs_mute_o       <= 1'b0;
      phase_detector_div_o <= 4'h1;
      cal_done_o           <= 1'b0;
    end
    else if (ce_i)
    begin
      cfg_load_o           <= (state_r == `ST_LOAD);
      coarse_calibration_o <= (state_r == `ST_COARSE); // RULE6
      fine_calibration_o   <= (state_r == `ST_FINE); // RULE6
      outputs_mute_o       <= cal_run && startup_r[`F_MUTE_CAL]; // RULE9
      // One-hot power of two divide of the reference
      phase_detector_div_o <= 4'h1 <<
        startup_r[`F_REFDIV_HI:`F_REFDIV_LO]; // RULE10
      cal_done_o           <= (state_r == `ST_DONE);
    end
  end

  // Feedback divider values driven by the sequencer in auto mode
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      fb_auto_o  <= 1'b0;
      fb_ndiv_o  <= 15'h0000;
      fb_presc_o <= 2'h0;
    end
    else if (ce_i)
    begin
      fb_auto_o <= startup_r[`F_FB_AUTO]; // RULE5
      if (cal_run && startup_r[`F_FB_AUTO])
      begin
        fb_ndiv_o  <= `FB_NDIV_AUTO; // RULE5
        fb_presc_o <= `FB_PRESC_AUTO; // RULE5
      end
    end
  end

  // Read mux; unmapped and write-only indices read zero
  always @*
  begin
    rdata_nxt = 16'h0000;
    case (idx)
      `REG_PTR_IDX:     rdata_nxt = {10'h000, ptr_r};
      `REG_WORD_IDX:    rdata_nxt = word_r;
      `REG_STARTUP_IDX: rdata_nxt = startup_r; // RULE15
      `REG_STATUS_IDX:  rdata_nxt = status_word;
      default:          rdata_nxt = 16'h0000;
    endcase
  end

  // Register read port, data one cycle after strobe
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      rdata_o <= 16'h0000;
    else if (ce_i)
      rdata_o <= rd_i ? rdata_nxt : 16'h0000;
  end

  // Serial pin glitch filters
  pin_glitch_filter #(.DEPTH(`FILT_CYCLES)) u_scl_filt (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .en_i      (startup_r[`F_SCL_FILT]), // RULE11
    .pin_i     (multi_pin_three_i),
    .pin_o     (serial_clock_o)
  );

  pin_glitch_filter #(.DEPTH(`FILT_CYCLES)) u_sda_filt (
    .ref_clk_i (ref_clk_i),
    .rstn_i    (rstn_i),
    .ce_i      (ce_i),
    .en_i      (startup_r[`F_SDA_FILT]), // RULE12
    .pin_i     (multi_pin_two_i),
    .pin_o     (serial_data_o)
  );
endmodule // startup_cal_and_nvm_program_ctrl
`default_nettype wire

// >>> tb/startup_ctrl_props.sv
`default_nettype none
// Watches the bus, NVM strobes and calibration outputs of the block
module startup_ctrl_props (
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic [7:0]  addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic        wr_i,
  input wire logic        nvm_prog_o,
  input wire logic [5:0]  nvm_prog_addr_o,
  input wire logic [15:0] nvm_prog_data_o,
  input wire logic        nvm_commit_o,
  input wire logic        coarse_calibration_o,
  input wire logic        fine_calibration_o,
  input wire logic        outputs_mute_o,
  input wire logic [3:0]  phase_detector_div_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  wire cal = coarse_calibration_o | fine_calibration_o;
  // Program and commit pulses follow their own register writes
  a_prog_cause: assert property (
    nvm_prog_o |-> $past(wr_i && addr_i[7:2] == 6'h0E))
    else $error("program pulse without a word write");
  a_prog_data: assert property (
    nvm_prog_o |-> nvm_prog_data_o == $past(wdata_i))
    else $error("programmed word differs from written word");
  a_ptr_step: assert property (
    nvm_prog_o && $past(nvm_prog_o) |->
      nvm_prog_addr_o == $past(nvm_prog_addr_o) + 6'h01)
    else $error("program address did not step by one");
  a_commit_cause: assert property (
    nvm_commit_o |-> $past(wr_i && addr_i[7:2] == 6'h11 && wdata_i[0]))
    else $error("commit pulse without a commit command");
  // Rounds run one at a time, coarse before fine
  a_fine_after: assert property (
    $rose(fine_calibration_o) |-> $past(coarse_calibration_o))
    else $error("fine round did not follow coarse round");
  a_rounds_apart: assert property (
    !(coarse_calibration_o && fine_calibration_o))
    else $error("both rounds active together");
  a_mute_in_cal: assert property (
    outputs_mute_o |-> cal)
    else $error("outputs muted outside calibration");
  a_div_onehot: assert property (
    $onehot(phase_detector_div_o))
    else $error("reference divider not one-hot");
  // Main scenarios
  c_back_to_back: cover property (nvm_prog_o ##1 nvm_prog_o);
  c_fine_round: cover property ($rose(fine_calibration_o));
  c_commit: cover property (nvm_commit_o);
endmodule // startup_ctrl_props
`default_nettype wire

// >>> tb/nvm_model.sv
`default_nettype none
// Behavioural NVM: keeps programmed words, may stay busy after each
module nvm_model (
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        prog_i,
  input  wire logic [5:0]  addr_i,
  input  wire logic [15:0] data_i,
  input  wire logic        slow_i,
  output logic             busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [64];
  logic [2:0]  busy_r;
  assign busy_o = busy_r != 3'h0;
  // Store the word; a slow part then stays busy four cycles
  always @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
      busy_r <= 3'h0;
    else if (prog_i)
    begin
      mem[addr_i] <= data_i;
      busy_r <= slow_i ? 3'h4 : 3'h0;
    end
    else if (busy_r != 3'h0)
      busy_r <= busy_r - 3'h1;
endmodule // nvm_model
`default_nettype wire

// >>> tb/tb_startup_cal_and_nvm_program_ctrl.sv
`default_nettype none
bind startup_cal_and_nvm_program_ctrl startup_ctrl_props u_props (
  .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .nvm_prog_o(nvm_prog_o),
  .nvm_prog_addr_o(nvm_prog_addr_o), .nvm_prog_data_o(nvm_prog_data_o),
  .nvm_commit_o(nvm_commit_o), .coarse_calibration_o(coarse_calibration_o),
  .fine_calibration_o(fine_calibration_o),
  .outputs_mute_o(outputs_mute_o),
  .phase_detector_div_o(phase_detector_div_o));
module tb_startup_cal_and_nvm_program_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rstn = 0, srst = 0, wr = 0, rd = 0, slow = 0;
  logic p3 = 1, p2 = 1;
  logic [7:0] addr = 0;
  logic [15:0] wd = 0, rv;
  wire [15:0] rdat, pdat;
  wire [5:0] pa;
  wire [3:0] div;
  wire [14:0] fnd;
  wire [1:0] fps;
  wire fa;
  wire sc, sd, pg, cm, ld, bsy, cf, ff, mu, dn;
  int n_fail = 0, total_checks = 0, n_p = 0, n_cm = 0, n_c = 0, n_l = 0;
  startup_cal_and_nvm_program_ctrl #(.ROUND_CYCLES(16), .LOAD_CYCLES(4)) dut (
    .ref_clk_i(clk), .rstn_i(rstn), .soft_rst_i(srst), .ce_i(1'b1),
    .addr_i(addr), .wdata_i(wd), .wr_i(wr), .rd_i(rd), .rdata_o(rdat),
    .multi_pin_three_i(p3), .multi_pin_two_i(p2), .serial_clock_o(sc),
    .serial_data_o(sd), .nvm_prog_o(pg), .nvm_prog_addr_o(pa),
    .nvm_prog_data_o(pdat), .nvm_commit_o(cm), .cfg_load_o(ld),
    .nvm_busy_i(bsy), .coarse_calibration_o(cf), .fine_calibration_o(ff),
    .outputs_mute_o(mu), .phase_detector_div_o(div), .fb_auto_o(fa),
    .fb_ndiv_o(fnd), .fb_presc_o(fps), .cal_done_o(dn));
  nvm_model nvm (.ref_clk_i(clk), .rstn_i(rstn), .prog_i(pg), .addr_i(pa),
    .data_i(pdat), .slow_i(slow), .busy_o(bsy));
  always #25 clk = ~clk;
  // Event counters for pulses and phases
  always @(posedge clk)
  begin
    n_p <= n_p + int'(pg);
    n_cm <= n_cm + int'(cm);
    n_c <= n_c + int'(cf);
    n_l <= n_l + int'(ld);
  end
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", nm, e, s);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task wrr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wd <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rdr(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdat;
  endtask
  // Waits for coarse (0), fine (1) or done (2), bounded
  task wt(input int k);
    for (int i = 0; i < 400; i++)
    begin
      @(posedge clk);
      #1;
      if ((k == 0) ? cf : (k == 1) ? ff : dn) return;
    end
    chk("wait", 16'h0, 16'h1);
    results();
  endtask
  task t_seq;
    rdr(8'h3C, rv); chk("startup", rv, 16'h0037);
    wt(0); chk("mute", 16'(mu), 16'h1);
    chk("div", 16'(div), 16'h4);
    chk("ndiv", 16'(fnd), 16'h0000);
    wt(1); chk("coarse", 16'(cf), 16'h0);
    wt(2); $display("sequence test done");
  endtask
  task t_lock;
    wrr(8'h34, 16'h0010); wrr(8'h38, 16'h1234); wrr(8'h44, 16'h0001);
    wrr(8'h3C, 16'h6037); wrr(8'h38, 16'h4321); wrr(8'h44, 16'h0001);
    rdr(8'h40, rv); chk("refused", rv & 16'h00C0, 16'h00C0);
    chk("prog", 16'(n_p), 16'h0);
    chk("commit", 16'(n_cm), 16'h0);
    $display("lock test done");
  endtask
  task t_prog;
    wrr(8'h3C, 16'h5037); wrr(8'h34, 16'h003F);
    @(posedge clk);
    addr <= 8'h38; wd <= 16'hA5A5; wr <= 1'b1;
    @(posedge clk);
    wd <= 16'h5A5A;
    @(posedge clk);
    wr <= 1'b0;
    wrr(8'h44, 16'h0001);
    @(posedge clk);
    #1;
    chk("w63", nvm.mem[63], 16'hA5A5);
    chk("w0", nvm.mem[0], 16'h5A5A);
    chk("commit", 16'(n_cm), 16'h1);
    slow <= 1'b1;
    wrr(8'h38, 16'h1111); wrr(8'h38, 16'h2222);
    slow <= 1'b0;
    chk("w1", nvm.mem[1], 16'h1111);
    chk("prog", 16'(n_p), 16'h3);
    $display("program test done");
  endtask
  task t_div;
    for (int v = 0; v < 4; v++)
    begin
      wrr(8'h3C, 16'h0107 | 16'(v << 3) | 16'((v & 1) << 5));
      wrr(8'h44, 16'h0002);
      wt(0); chk("div", 16'(div), 16'(1 << v));
      chk("mute", 16'(mu), 16'(v & 1));
      chk("fbauto", 16'(fa), 16'h0001);
      chk("ndiv", 16'(fnd), 16'h0064);
      chk("presc", 16'(fps), 16'h0001);
      wt(2);
    end
    $display("divider test done");
  endtask
  task t_pins;
    wrr(8'h3C, 16'h0E37); rdr(8'h3C, rv); chk("rsvd", rv, 16'h0E37);
    @(posedge clk);
    p3 <= 1'b0; p2 <= 1'b0;
    @(posedge clk);
    p3 <= 1'b1; p2 <= 1'b1;
    repeat (4)
    begin
      @(posedge clk);
      #1 chk("scl", 16'(sc), 16'h1);
      chk("sda", 16'(sd), 16'h1);
    end
    wrr(8'h3C, 16'h0031);
    @(posedge clk);
    p3 <= 1'b0; p2 <= 1'b0;
    #1 chk("scl", 16'(sc), 16'h0);
    chk("sda", 16'(sd), 16'h0);
    $display("pin test done");
  endtask
  task t_skip;
    int c, l;
    wrr(8'h3C, 16'h00C7);
    c = n_c; l = n_l;
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    repeat (48) @(posedge clk);
    chk("coarse", 16'(n_c - c), 16'h0);
    chk("load", 16'(n_l - l), 16'h0);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdr(8'h3C, rv); chk("startup", rv, 16'h0037);
    wt(0); wt(2);
    $display("skip test done");
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_seq(); t_lock(); t_prog(); t_div(); t_pins(); t_skip();
    results();
  end
endmodule // tb_startup_cal_and_nvm_program_ctrl
`default_nettype wire
